/* File: shared/sas_pkg.sv */
// constants, types and helpers for the sar adc sequencer
package sas_pkg;
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h3c;
  localparam logic [7:0] ADDR_RESULT = 8'h3d;
  localparam logic [7:0] ADDR_CLK    = 8'h3e;
  // control register fields
  localparam int BIT_DONE = 7;
  localparam int BIT_IEN  = 6;
  localparam int BIT_CONT = 5;
  localparam int CH_W     = 5;
  localparam int DIV_W    = 3;
  // channel codes
  localparam logic [4:0] CH_PORT_LAST = 5'h03;
  localparam logic [4:0] CH_REF_HI    = 5'h1d;
  localparam logic [4:0] CH_REF_LO    = 5'h1e;
  localparam logic [4:0] CH_OFF       = 5'h1f;
  // reset values
  localparam logic [4:0] CH_RESET     = 5'h1f;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [2:0] DIV_RESET    = 3'h0;
  // conversion timing: tick 0 samples, 1..8 decide bits, 16 completes
  localparam logic [4:0] CONV_LAST    = 5'h10;
  localparam logic [7:0] SAR_MSB      = 8'h80;
  localparam int         CONV_MIN_CLK = 16;
  localparam int         CONV_MAX_CLK = 17;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } sas_state_e;

  // converter clock divide ratio from the prescaler field
  function automatic logic [4:0] sas_div_ratio(input logic [2:0] div);
    if (div[2])
      return 5'h10;
    else
      return 5'(5'h01 << div[1:0]);
  endfunction

  // one-hot port line chosen by the channel field, zero for non-port codes
  function automatic logic [3:0] sas_port_sel(input logic [4:0] ch);
    if (ch <= CH_PORT_LAST)
      return 4'(4'h1 << ch[1:0]);
    else
      return 4'h0;
  endfunction
endpackage

/* File: shared/sas_link_if.sv */
// link between the sequencer core, its prescaler and its port override
`timescale 1ns/100ps
interface sas_link_if;
  logic [2:0] div_sel;
  logic       tick;
  logic [4:0] ch;
  modport ctl (output div_sel, output ch, input tick);
  modport pre (input div_sel, output tick);
  modport prt (input ch);
endinterface

/* File: core/sas_prescaler.sv */
// converter clock prescaler producing a one-cycle tick enable
`timescale 1ns/100ps
module sas_prescaler
  import sas_pkg::*;
(
  input  logic    sys_clk,
  input  logic    rst,
  sas_link_if.pre lk
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } sas_pre_s;

  sas_pre_s q;
  sas_pre_s next_q;
  logic [3:0] lim;

  // free running, so a start lands anywhere within a tick period
  always_comb
  begin
    lim    = 4'(sas_div_ratio(lk.div_sel) - 5'h01);
    next_q = q;
    next_q.tick = (q.cnt >= lim);
    next_q.cnt  = (q.cnt >= lim) ? 4'h0 : q.cnt + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign lk.tick = q.tick;
endmodule

/* File: core/sas_port_mux.sv */
// shared port line override for the converter input
`timescale 1ns/100ps
module sas_port_mux
  import sas_pkg::*;
#(
  parameter int LINES = 4
)
(
  sas_link_if.prt           lk,
  input  logic [LINES-1:0]  port_latch,
  input  logic [LINES-1:0]  port_dir,
  input  logic [LINES-1:0]  shared_port_lines_in,
  output logic [LINES-1:0]  port_read,
  output logic [LINES-1:0]  shared_port_lines_out,
  output logic [LINES-1:0]  shared_port_lines_oe_n
);
  logic [3:0] sel;

  assign sel = sas_port_sel(lk.ch);

  // per line: converter takes the pin, gpio keeps latch readback on output lines and input lines read zero
  for (genvar i = 0; i < LINES; i++)
  begin : g_line
    assign shared_port_lines_out[i]  = port_latch[i];
    assign shared_port_lines_oe_n[i] = ~(port_dir[i] & ~sel[i]);
    assign port_read[i] = sel[i] ? (port_dir[i] & port_latch[i])
                                 : (port_dir[i] ? port_latch[i] : shared_port_lines_in[i]);
  end
endmodule

/* File: core/sas_core.sv */
// sar adc sequencer: registers, conversion control and completion signalling
`timescale 1ns/100ps
module sas_core
  import sas_pkg::*;
(
  input  logic       sys_clk,
  input  logic       rst,
  input  logic [7:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_wr,
  input  logic       reg_rd,
  output logic [7:0] reg_rdata,
  input  logic       stop_mode,
  input  logic       comp_above,
  output logic [7:0] dac_code,
  output logic [4:0] selected_analog_input,
  output logic       analog_power_en,
  output logic       conv_irq,
  output logic       dma_req,
  input  logic [3:0] port_latch,
  input  logic [3:0] port_dir,
  input  logic [3:0] shared_port_lines_in,
  output logic [3:0] port_read,
  output logic [3:0] shared_port_lines_out,
  output logic [3:0] shared_port_lines_oe_n
);
  typedef struct packed {
    sas_state_e state;
    logic [4:0] cnt;
    logic [7:0] trial;
    logic [7:0] mask;
    logic [7:0] result;
    logic       conversion_done_flag;
    logic       conversion_irq_enable;
    logic       continuous_convert_bit;
    logic [4:0] input_channel_select;
    logic       route_dma;
    logic       irq_pend;
    logic       resume;
    logic [2:0] div;
    logic [7:0] rdata;
  } sas_core_s;

  sas_core_s  q;
  sas_core_s  next_q;
  sas_link_if lk ();

  logic evt;
  logic start;
  logic wr_ctrl;
  logic rd_res;
  logic cmp;

  // channel field decode shared by start, resume and power control
  function automatic logic is_powered(input logic [4:0] ch);
    return ch != CH_OFF;
  endfunction

  sas_prescaler u_pre (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lk      (lk.pre)
  );

  sas_port_mux #(.LINES(4)) u_port (
    .lk                     (lk.prt),
    .port_latch             (port_latch),
    .port_dir               (port_dir),
    .shared_port_lines_in   (shared_port_lines_in),
    .port_read              (port_read),
    .shared_port_lines_out  (shared_port_lines_out),
    .shared_port_lines_oe_n (shared_port_lines_oe_n)
  );

  assign lk.div_sel = q.div;
  assign lk.ch      = q.input_channel_select;

  // reference channels force the comparator so they read full scale or zero
  always_comb
  begin
    if (q.input_channel_select == CH_REF_HI)
      cmp = 1'b1;
    else if (q.input_channel_select == CH_REF_LO)
      cmp = 1'b0;
    else
      cmp = comp_above;
  end

  // sequencer next state; clears come first so completion sets win
  always_comb
  begin
    next_q       = q;
    next_q.rdata = 8'h00;
    wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    rd_res  = reg_rd && (reg_addr == ADDR_RESULT);
    evt     = (q.state == ST_CONV) && lk.tick && (q.cnt == CONV_LAST);
    start   = 1'b0;

    // register reads, unmapped addresses answer zero
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL:   next_q.rdata = {q.conversion_done_flag & ~q.conversion_irq_enable,
                                     q.conversion_irq_enable, q.continuous_convert_bit,
                                     q.input_channel_select};
        ADDR_RESULT: next_q.rdata = q.result;
        ADDR_CLK:    next_q.rdata = {5'h00, q.div};
        default:     next_q.rdata = 8'h00;
      endcase
    end

    // successive approximation: keep or drop the trial bit, try the next
    if (q.state == ST_CONV && lk.tick)
    begin
      next_q.cnt = q.cnt + 5'h01;
      if (q.cnt == 5'h00)
      begin
        next_q.trial = SAR_MSB;
        next_q.mask  = SAR_MSB;
      end
      else if (q.mask != 8'h00)
      begin
        next_q.mask  = q.mask >> 1;
        next_q.trial = (cmp ? q.trial : (q.trial & ~q.mask)) | (q.mask >> 1);
      end
    end

    // a result read drops the flag and any pending request
    if (rd_res)
    begin
      next_q.conversion_done_flag = 1'b0;
      next_q.irq_pend             = 1'b0;
    end
    if (wr_ctrl)
    begin
      next_q.conversion_done_flag   = 1'b0;
      next_q.irq_pend               = 1'b0;
      next_q.conversion_irq_enable  = reg_wdata[BIT_IEN];
      next_q.continuous_convert_bit = reg_wdata[BIT_CONT];
      next_q.input_channel_select   = reg_wdata[CH_W-1:0];
      // dma routing only latches with interrupts on; software should not
      next_q.route_dma = reg_wdata[BIT_DONE] & reg_wdata[BIT_IEN];
    end
    if (reg_wr && reg_addr == ADDR_CLK)
      next_q.div = reg_wdata[DIV_W-1:0]; // a change mid conversion corrupts it

    // completion: overwrite result unconditionally, then flag or request;
    // the enable after a same-cycle write decides, so no request outlives it
    if (evt)
    begin
      next_q.result = q.trial;
      if (next_q.conversion_irq_enable)
        next_q.irq_pend = 1'b1;
      else
        next_q.conversion_done_flag = 1'b1;
      if (q.continuous_convert_bit)
        start = 1'b1;
      else
        next_q.state = ST_IDLE;
    end

    // a control write restarts with the new settings unless powered off
    if (wr_ctrl)
    begin
      start = is_powered(reg_wdata[CH_W-1:0]);
      if (!start)
        next_q.state = ST_IDLE;
    end

    // stop aborts and remembers to resume; wait mode needs no handling
    if (stop_mode)
    begin
      if (q.state == ST_CONV || start)
        next_q.resume = 1'b1;
      next_q.state = ST_IDLE;
      start = 1'b0;
    end
    else if (q.resume)
    begin
      next_q.resume = 1'b0;
      // next channel, so a power-off write in this cycle is not overridden
      start = is_powered(next_q.input_channel_select);
    end

    if (start)
    begin
      next_q.state = ST_CONV;
      next_q.cnt   = 5'h00;
      next_q.mask  = 8'h00;
    end
  end

  // single register stage for the whole block
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.input_channel_select <= CH_RESET;
      q.result <= RESULT_RESET;
      q.div    <= DIV_RESET;
    end
    else
      q <= next_q;
  end

  // outputs; the cpu request stays high until a result read or control write, waking from wait
  assign reg_rdata             = q.rdata;
  assign dac_code              = q.trial;
  assign selected_analog_input = q.input_channel_select;
  assign analog_power_en       = is_powered(q.input_channel_select);
  assign conv_irq              = q.irq_pend & ~q.route_dma;
  assign dma_req               = q.irq_pend & q.route_dma;

  // helper: cycles since the last start, for the length check
  int hc_cyc;
  always_ff @(posedge sys_clk)
  begin
    if (rst || start)
      hc_cyc <= 0;
    else if (hc_cyc < 1000)
      hc_cyc <= hc_cyc + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_start;
    wr_ctrl && (reg_wdata[4:0] != CH_OFF) && !stop_mode |=> q.state == ST_CONV;
  endproperty
  a_start: assert property (p_start) else $error("write did not start conversion");

  property p_len;
    evt |-> hc_cyc >= CONV_MIN_CLK * int'(sas_div_ratio(q.div)) - 1
            && hc_cyc <= CONV_MAX_CLK * int'(sas_div_ratio(q.div));
  endproperty
  a_len: assert property (p_len) else $error("conversion length out of range");

  property p_store;
    evt && !wr_ctrl && !reg_rd |=> reg_rdata == 8'h00 && q.result == $past(q.trial);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_flag;
    evt && !q.conversion_irq_enable && !wr_ctrl ##1 reg_rd && reg_addr == ADDR_CTRL
      |=> reg_rdata[BIT_DONE];
  endproperty
  a_flag: assert property (p_flag) else $error("done flag not set");

  property p_clr;
    rd_res && !evt |=> !q.conversion_done_flag && !conv_irq && !dma_req;
  endproperty
  a_clr: assert property (p_clr) else $error("result read did not clear");

  property p_irq;
    evt && q.conversion_irq_enable && !q.route_dma && !wr_ctrl |=> conv_irq && !dma_req;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_route;
    conv_irq || dma_req |-> q.conversion_irq_enable || $past(q.conversion_irq_enable);
  endproperty
  a_route: assert property (p_route) else $error("request without enable");

  property p_ien_zero;
    reg_rd && reg_addr == ADDR_CTRL && q.conversion_irq_enable |=> !reg_rdata[BIT_DONE];
  endproperty
  a_ien_zero: assert property (p_ien_zero) else $error("done flag visible with ien");

  property p_single;
    evt && !q.continuous_convert_bit && !reg_wr && !stop_mode && !q.resume ##1 !reg_wr
      |-> q.state == ST_IDLE [*2];
  endproperty
  a_single: assert property (p_single) else $error("single mode did not idle");

  property p_cont;
    evt && q.continuous_convert_bit && !reg_wr && !stop_mode |=> q.state == ST_CONV
      && q.cnt == 5'h00;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode stopped");

  property p_stop;
    stop_mode |=> q.state == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion ran in stop");

  property p_off;
    q.input_channel_select == CH_OFF |-> !analog_power_en && q.state == ST_IDLE;
  endproperty
  a_off: assert property (p_off) else $error("converter on with channel off");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_wr_clr;
    wr_ctrl && !evt |=> !q.conversion_done_flag && !conv_irq && !dma_req;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("control write did not clear");

  property p_dma;
    evt && q.conversion_irq_enable && q.route_dma && !wr_ctrl |=> dma_req && !conv_irq;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request not routed");

  property p_ref_hi;
    evt && q.input_channel_select == CH_REF_HI |=> q.result == 8'hff;
  endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("high reference not full scale");

  property p_ref_lo;
    evt && q.input_channel_select == CH_REF_LO |=> q.result == 8'h00;
  endproperty
  a_ref_lo: assert property (p_ref_lo) else $error("low reference not zero");

  property p_msb;
    q.state == ST_CONV && lk.tick && q.cnt == 5'h00 |=> dac_code == SAR_MSB;
  endproperty
  a_msb: assert property (p_msb) else $error("search did not start at msb");

  property p_cnt;
    q.state == ST_CONV |-> q.cnt <= CONV_LAST;
  endproperty
  a_cnt: assert property (p_cnt) else $error("tick count ran past completion");

  property p_resume;
    !stop_mode && q.resume && !reg_wr && is_powered(q.input_channel_select)
      |=> q.state == ST_CONV && q.cnt == 5'h00;
  endproperty
  a_resume: assert property (p_resume) else $error("no restart after stop");

  property p_port;
    q.input_channel_select <= CH_PORT_LAST
      |-> shared_port_lines_oe_n[q.input_channel_select[1:0]];
  endproperty
  a_port: assert property (p_port) else $error("selected line still driven");

  property p_port_rd;
    q.input_channel_select <= CH_PORT_LAST && !port_dir[q.input_channel_select[1:0]]
      |-> !port_read[q.input_channel_select[1:0]];
  endproperty
  a_port_rd: assert property (p_port_rd) else $error("selected input line not zero");

  c_single: cover property (evt && !q.continuous_convert_bit);
  c_back:   cover property (evt && q.continuous_convert_bit ##[1:300] evt);
  c_abort:  cover property (q.state == ST_CONV && stop_mode);
  c_irq:    cover property ($rose(conv_irq));
  c_dma:    cover property ($rose(dma_req));
endmodule

/* File: verif/sas_analog_model.sv */
// behavioural analog front end and pad model facing the converter
`timescale 1ns/100ps
module sas_analog_model
  import sas_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [31:0] levels,
  input  wire logic [3:0]  pad_drive,
  input  wire logic [7:0]  dac_code,
  input  wire logic [4:0]  selected_analog_input,
  input  wire logic        analog_power_en,
  input  wire logic [3:0]  shared_port_lines_out,
  input  wire logic [3:0]  shared_port_lines_oe_n,
  output logic             comp_above,
  output logic [3:0]       shared_port_lines_in
);
  logic       junk = 1'b0;
  logic [7:0] vin;

  // unpowered or unused input: comparator flips every cycle, never a stable guess
  always_ff @(posedge sys_clk)
  begin
    junk <= ~junk;
  end

  // half an lsb offset so the search lands exactly on the level
  always_comb
  begin
    vin = 8'h00;
    if (selected_analog_input <= CH_PORT_LAST)
      vin = levels[8*selected_analog_input[1:0] +: 8];
    else if (selected_analog_input == CH_REF_HI)
      vin = 8'hff;
    comp_above = {vin, 1'b1} > {dac_code, 1'b0};
    if (!analog_power_en || (selected_analog_input > CH_PORT_LAST && selected_analog_input < CH_REF_HI))
      comp_above = junk;
  end

  // released pads follow the outside world, driven pads follow the port
  assign shared_port_lines_in = (shared_port_lines_oe_n & pad_drive)
                              | (~shared_port_lines_oe_n & shared_port_lines_out);
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the sar adc sequencer
`timescale 1ns/100ps
module testbench
  import sas_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        stop_mode = 1'b0;
  logic [3:0]  port_latch = 4'h0;
  logic [3:0]  port_dir = 4'h0;
  logic [31:0] levels = 32'h0;
  logic [3:0]  pad_drive = 4'h0;
  logic [7:0]  reg_rdata, dac_code;
  logic [4:0]  sel;
  logic        comp_above, pwr, conv_irq, dma_req;
  logic [3:0]  pins_in, port_read, pins_out, pins_oe_n;
  logic [7:0]  exp_q[$];
  int          fail_count = 0;
  int          compares = 0;
  logic [4:0]  chs [6] = '{5'h00, 5'h01, 5'h02, 5'h03, CH_REF_HI, CH_REF_LO};

  sas_core dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
    .comp_above(comp_above), .dac_code(dac_code), .selected_analog_input(sel),
    .analog_power_en(pwr), .conv_irq(conv_irq), .dma_req(dma_req), .port_latch(port_latch),
    .port_dir(port_dir), .shared_port_lines_in(pins_in), .port_read(port_read),
    .shared_port_lines_out(pins_out), .shared_port_lines_oe_n(pins_oe_n));

  sas_analog_model far (.sys_clk(sys_clk), .levels(levels), .pad_drive(pad_drive),
    .dac_code(dac_code), .selected_analog_input(sel), .analog_power_en(pwr),
    .shared_port_lines_out(pins_out), .shared_port_lines_oe_n(pins_oe_n),
    .comp_above(comp_above), .shared_port_lines_in(pins_in));

  // free-running 25 MHz clock
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one strobe cycle; for a read, data is the expected answer
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= addr;
    reg_wdata <= data;
    if (!wr)
      exp_q.push_back(data);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // latency from the write edge to the interrupt, window scaled by the divide ratio
  task automatic irq_time(input int r);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (conv_irq !== 1'b1 && n < 400);
    if (n == 400)
    begin
      fail_count++;
      finish_test();
    end
    check("irq latency in window", 8'h01, 8'(n - 1 >= 16 * r && n - 1 <= 17 * r + 1));
  endtask

  function automatic logic [7:0] lvl(input logic [4:0] ch);
    if (ch <= CH_PORT_LAST)
      return levels[8*ch[1:0] +: 8];
    return (ch == CH_REF_HI) ? 8'hff : 8'h00;
  endfunction

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      check("read data", exp_q.pop_front(), reg_rdata);
  end

  initial
  begin
    logic [7:0] v;
    logic [4:0] c;
    void'($urandom(26869));
    levels <= $urandom();
    pad_drive <= 4'($urandom());
    idle(4);
    rst <= 1'b0;
    bus(0, ADDR_CTRL, {3'b000, CH_RESET});
    bus(0, ADDR_RESULT, RESULT_RESET);
    bus(0, ADDR_CLK, {5'h00, DIV_RESET});
    bus(0, 8'h55, 8'h00);
    check("power", 8'h00, pwr);
    $display("test reset done");
    foreach (chs[i])
    begin
      c = chs[i];
      bus(1, ADDR_CTRL, {3'b000, c});
      idle(10);
      bus(0, ADDR_CTRL, {3'b000, c});
      idle(8);
      bus(0, ADDR_CTRL, {3'b100, c});
      bus(0, ADDR_RESULT, lvl(c));
      bus(0, ADDR_CTRL, {3'b000, c});
    end
    $display("test channels done");
    for (int d = 0; d < 5; d++)
    begin
      c = 5'(d & 3);
      bus(1, ADDR_CLK, (d == 4) ? 8'h07 : 8'(d));
      bus(1, ADDR_CTRL, {3'b010, c});
      irq_time((d == 4) ? 16 : (1 << d));
      check("dma idle", 8'h00, dma_req);
      bus(0, ADDR_CTRL, {3'b010, c});
      bus(0, ADDR_RESULT, lvl(c));
      @(negedge sys_clk);
      check("irq after read", 8'h00, conv_irq);
    end
    bus(1, ADDR_CLK, 8'h00);
    bus(1, ADDR_CTRL, 8'hc1);
    idle(25);
    check("dma routed", 8'h01, dma_req);
    check("cpu irq off", 8'h00, conv_irq);
    bus(0, ADDR_CTRL, 8'h41);
    bus(1, ADDR_CTRL, 8'h01);
    @(negedge sys_clk);
    check("dma after write", 8'h00, dma_req);
    $display("test interrupt done");
    bus(1, ADDR_CTRL, 8'h22);
    idle(25);
    levels <= $urandom();
    idle(40);
    bus(0, ADDR_CTRL, 8'ha2);
    bus(0, ADDR_RESULT, lvl(2));
    idle(20);
    bus(0, ADDR_CTRL, 8'ha2);
    repeat (20) bus(0, ADDR_CTRL, 8'ha2);
    bus(1, ADDR_CTRL, 8'h02);
    idle(25);
    v = lvl(2);
    bus(0, ADDR_RESULT, v);
    levels <= ~levels;
    idle(40);
    bus(0, ADDR_CTRL, 8'h02);
    bus(0, ADDR_RESULT, v);
    $display("test continuous done");
    bus(1, ADDR_CTRL, 8'h00);
    idle(8);
    bus(1, ADDR_CTRL, 8'h01);
    idle(10);
    bus(0, ADDR_CTRL, 8'h01);
    idle(8);
    bus(0, ADDR_RESULT, lvl(1));
    bus(1, ADDR_CTRL, 8'h03);
    idle(5);
    stop_mode <= 1'b1;
    idle(40);
    bus(0, ADDR_CTRL, 8'h03);
    stop_mode <= 1'b0;
    idle(20);
    bus(0, ADDR_CTRL, 8'h83);
    bus(1, ADDR_CTRL, 8'h1f);
    idle(30);
    bus(0, ADDR_CTRL, 8'h1f);
    check("power", 8'h00, pwr);
    $display("test abort stop done");
    bus(1, ADDR_CTRL, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      port_latch <= 4'($urandom());
      port_dir <= 4'($urandom());
      @(negedge sys_clk);
      check("selected read", port_dir[2] & port_latch[2], port_read[2]);
      check("selected oe_n", 8'h01, pins_oe_n[2]);
      check("gpio oe_n", !port_dir[1], pins_oe_n[1]);
      check("gpio out", port_latch[1], pins_out[1]);
      check("gpio in", port_dir[0] ? port_latch[0] : pad_drive[0], port_read[0]);
    end
    $display("test port done");
    finish_test();
  end
endmodule
